// ### bench/swl_master_model.sv
`timescale 1ns/10ps
module swl_master_model (
  input wire logic clk_in,
  input wire logic current_in,
  output logic line_out
);
  logic samp_q[$];

  // Line starts low: the link is off until the bench raises it
  initial line_out = 1'h0;

  ////////////////////////////////////////////////////////////////
  task automatic hold(input logic lvl, input int n);
    line_out = lvl;
    repeat (n) @(negedge clk_in);
  endtask : hold

  // Rise opens the bit and the next rise closes it, with no gap
  task automatic send_bit(input int per, input int high);
    hold(1'h1, high);
    // Current read at the end of the high phase, where it is valid
    samp_q.push_back(current_in);
    hold(1'h0, per - high);
  endtask : send_bit

  // Nominal high time: three quarters for one, a quarter for zero
  task automatic send_nom(input logic val, input int per);
    send_bit(per, val ? per * 3 / 4 : per / 4);
  endtask : send_nom

  // Idle bits carry zero
  task automatic idle_bits(input int n, input int per);
    repeat (n) send_nom(1'h0, per);
  endtask : idle_bits

  // Transition sequence, then exactly eight idle bits
  task automatic resume(input int per);
    hold(1'h0, 8);
    idle_bits(8, per);
  endtask : resume

  // Suspend only after seven idle-only bits, then the line stays high
  task automatic suspend(input int per);
    idle_bits(7, per);
    hold(1'h1, 1100);
  endtask : suspend
endmodule : swl_master_model

// ### bench/swl_phy_tb.sv
`timescale 1ns/10ps
module swl_phy_tb;
  // 160 ns link bit at a 10 ns clock
  localparam int PER = 16;
  localparam int SAVE = 50;
  logic clk_in, reset_n_in, line, cur, cur_d, tx_valid, tx_ready, rx_bit, rx_valid;
  logic others_idle, low_req, full_cmd;
  logic [7:0] tx_data;
  swl_pkg::swl_link_t link;
  swl_pkg::swl_pwr_t pwr;
  int n_mismatch = 0;
  int num_checks = 0;
  int cyc = 0;
  logic rx_q[$];

  swl_phy #(.SAVE_CYC(SAVE)) dut_u (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .shared_line_in(line), .slave_current_out(cur), .tx_data_in(tx_data),
    .tx_valid_in(tx_valid), .tx_ready_out(tx_ready), .rx_bit_out(rx_bit),
    .rx_valid_out(rx_valid), .link_state_out(link), .others_idle_in(others_idle),
    .low_power_req_in(low_req), .full_power_cmd_in(full_cmd), .pwr_status_out(pwr));

  swl_master_model mdl_u (.clk_in(clk_in), .current_in(cur), .line_out(line));

  ////////////////////////////////////////////////////////////////
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : chk

  function automatic int first_one();
    foreach (mdl_u.samp_q[i]) if (mdl_u.samp_q[i] === 1'h1) return i;
    return 0;
  endfunction : first_one

  // Bytes leave MSB first, one bit per master bit
  task automatic chk_byte(input int at, input logic [7:0] b);
    for (int j = 0; j < 8; j++) chk("tx_bit", mdl_u.samp_q[at + j], b[7 - j]);
  endtask : chk_byte

  ////////////////////////////////////////////////////////////////
  always @(posedge clk_in) begin
    if (rx_valid === 1'h1) rx_q.push_back(rx_bit);
    if (link === swl_pkg::SWL_LINK_ACTIVE && cur !== cur_d) chk("cur_switch", line, 1'h0);
    cur_d <= cur;
    cyc <= cyc + 1;
    // Whole run needs about 11000 cycles
    if (cyc == 20000) begin
      n_mismatch++;
      stop_test();
    end
  end

  task automatic t_reset();
    chk("link", link, swl_pkg::SWL_LINK_OFF);
    chk("current", cur, 1'h0);
    chk("pwr", pwr, 3'h0);
    chk("tx_ready", tx_ready, 1'h1);
    $display("test reset done");
  endtask : t_reset

  task automatic t_activate();
    mdl_u.hold(1'h1, 20);
    chk("link", link, swl_pkg::SWL_LINK_PAUSED);
    chk("current", cur, 1'h0);
    chk("operational", pwr.operational, 1'h0);
    $display("test activate done");
  endtask : t_activate

  task automatic t_master_resume();
    rx_q.delete();
    mdl_u.samp_q.delete();
    low_req = 1'h1;
    // A byte offered after the fall must go out during the idle bits
    fork
      mdl_u.resume(PER);
      begin
        repeat (4) @(negedge clk_in);
        tx_data = 8'h96;
        tx_valid = 1'h1;
        @(negedge clk_in);
        tx_valid = 1'h0;
      end
    join
    chk("link", link, swl_pkg::SWL_LINK_RESUMING);
    mdl_u.send_nom(1'h1, PER);
    low_req = 1'h0;
    chk("link", link, swl_pkg::SWL_LINK_ACTIVE);
    chk("rx_count", rx_q.size(), 8);
    foreach (rx_q[i]) chk("rx_idle", rx_q[i], 1'h0);
    chk("operational", pwr.operational, 1'h1);
    chk("low_power", pwr.low_power, 1'h1);
    chk_byte(1, 8'h96);
    $display("test master_resume done");
  endtask : t_master_resume

  task automatic t_power();
    full_cmd = 1'h1;
    @(negedge clk_in);
    full_cmd = 1'h0;
    low_req = 1'h1;
    chk("low_power", pwr.low_power, 1'h0);
    repeat (4) @(negedge clk_in);
    low_req = 1'h0;
    chk("low_power", pwr.low_power, 1'h0);
    chk("operational", pwr.operational, 1'h1);
    $display("test power done");
  endtask : t_power

  // Boundary fractions and periods; each bit judged on its own period
  task automatic t_decode();
    int per_a[10] = '{20, 20, 20, 20, 59, 59, 1000, 1000, 16, 16};
    int hi_a[10] = '{14, 16, 4, 6, 42, 17, 250, 750, 12, 4};
    rx_q.delete();
    foreach (per_a[i]) mdl_u.send_bit(per_a[i], hi_a[i]);
    mdl_u.send_nom(1'h0, PER);
    chk("rx_count", rx_q.size(), 11);
    chk("rx_bit", rx_q[0], 1'h1);
    foreach (per_a[i]) chk("rx_bit", rx_q[i + 1], hi_a[i] * 2 > per_a[i]);
    $display("test decode done");
  endtask : t_decode

  // Master stalls while the buffer fills, then drains it with idle bits
  task automatic t_fifo_tx();
    int f;
    mdl_u.samp_q.delete();
    tx_valid = 1'h1;
    for (int i = 0; i < 16; i++) begin
      tx_data = 8'hA0 + 8'(i);
      chk("tx_ready", tx_ready, 1'h1);
      @(negedge clk_in);
    end
    tx_data = 8'h55;
    chk("tx_ready_full", tx_ready, 1'h0);
    @(negedge clk_in);
    tx_valid = 1'h0;
    mdl_u.idle_bits(140, PER);
    chk("tx_ready_empty", tx_ready, 1'h1);
    f = first_one();
    for (int k = 0; k < 16; k++) chk_byte(f + 8 * k, 8'hA0 + 8'(k));
    chk_byte(f + 128, 8'h00);
    $display("test fifo_tx done");
  endtask : t_fifo_tx

  task automatic t_suspend();
    mdl_u.suspend(PER);
    chk("link", link, swl_pkg::SWL_LINK_PAUSED);
    chk("current", cur, 1'h0);
    $display("test suspend done");
  endtask : t_suspend

  // Slow master answer, still inside 5 us
  task automatic t_slave_resume();
    int f;
    mdl_u.samp_q.delete();
    tx_data = 8'hC3;
    tx_valid = 1'h1;
    @(negedge clk_in);
    tx_valid = 1'h0;
    repeat (2) @(negedge clk_in);
    chk("link", link, swl_pkg::SWL_LINK_WAKE);
    chk("current", cur, 1'h1);
    mdl_u.hold(1'h0, 400);
    mdl_u.idle_bits(12, PER);
    chk("link", link, swl_pkg::SWL_LINK_ACTIVE);
    f = first_one();
    chk("sof_delay", f < 4, 1'h1);
    chk_byte(f, 8'hC3);
    $display("test slave_resume done");
  endtask : t_slave_resume

  task automatic t_shutdown_transition();
    mdl_u.suspend(PER);
    mdl_u.hold(1'h0, 2900);
    chk("link", link, swl_pkg::SWL_LINK_RESUMING);
    mdl_u.hold(1'h0, 200);
    chk("link", link, swl_pkg::SWL_LINK_OFF);
    chk("current", cur, 1'h0);
    others_idle = 1'h1;
    mdl_u.hold(1'h0, SAVE - 5);
    chk("power_save", pwr.power_save, 1'h0);
    mdl_u.hold(1'h0, 10);
    chk("power_save", pwr.power_save, 1'h1);
    mdl_u.hold(1'h1, 8);
    chk("power_save", pwr.power_save, 1'h0);
    chk("link", link, swl_pkg::SWL_LINK_PAUSED);
    $display("test shutdown_transition done");
  endtask : t_shutdown_transition

  ////////////////////////////////////////////////////////////////
  initial begin
    clk_in = 1'h0;
    forever #5 clk_in = ~clk_in;
  end

  initial begin
    reset_n_in = 1'h0;
    tx_valid = 1'h0;
    tx_data = 8'h00;
    others_idle = 1'h0;
    low_req = 1'h0;
    full_cmd = 1'h0;
    repeat (6) @(negedge clk_in);
    reset_n_in = 1'h1;
    t_reset();
    t_activate();
    t_master_resume();
    t_power();
    t_decode();
    t_fifo_tx();
    t_suspend();
    t_slave_resume();
    t_shutdown_transition();
    stop_test();
  end
endmodule : swl_phy_tb

// ### common/swl_pkg.sv
`include "swl_regs.svh"
package swl_pkg;
  typedef enum logic [4:0] {
    SWL_LINK_OFF = 5'b00001,
    SWL_LINK_PAUSED = 5'b00010,
    SWL_LINK_RESUMING = 5'b00100,
    SWL_LINK_WAKE = 5'b01000,
    SWL_LINK_ACTIVE = 5'b10000
  } swl_link_t;

  typedef struct packed {
    logic operational;
    logic low_power;
    logic power_save;
  } swl_pwr_t;

  typedef struct packed {
    logic sync1;
    logic sync2;
    logic line_d;
    logic have_edge;
    swl_link_t link;
    logic [`SWL_CNT_W-1:0] per_cnt;
    logic [`SWL_CNT_W-1:0] high_cnt;
    logic [`SWL_CNT_W-1:0] low_cnt;
    logic rx_bit;
    logic rx_valid;
    logic [3:0] idle_cnt;
    logic cur;
    logic [`SWL_FIFO_WIDTH-1:0] sh;
    logic [3:0] sh_cnt;
    logic resp_wait;
    logic [2:0] resp_cnt;
    swl_pwr_t pwr;
    logic full_locked;
    logic [`SWL_SAVE_W-1:0] save_cnt;
  } swl_phy_state_t;
endpackage : swl_pkg

// ### common/swl_regs.svh
// Notes on behaviour
// - Bits run back to back; each bit spans rising edge to next rising edge.
// - Each bit is decoded against its own period, whatever the period length.
// - A one has its high phase between 70 and 80 percent of the period.
// - A zero has its high phase between 20 and 30 percent of the period.
// - Bit period 1 to 5 us by default, 0.590 to 10 us when extended.
// - Slave changes its current only while the line voltage is low, except when it raises it for a slave resume while paused.
// - Paused: voltage high, current low; left only by resume or shutdown (a suspend leaves the current at the last bit sent).
// - Activated: bits flow both ways until the master suspends.
// - Deactivated: voltage and current low until activation.
// - After a master resume the slave may transmit during the idle bits.
// - Slave resumes by raising current; master answers within 5 us.
// - After a slave resume, slave starts its frame within four bits.
// - Line low over 30 us while paused means the link is deactivated.
// - First activation after power-up enters the operational power state.
// - Low-power frame at activation enters low power; only a command leaves it.
// - Full power never returns to low power without supply removal.
// - All interfaces idle and link off: power saving within 10 ms.
// - Power saving ends as soon as any interface resumes.
`ifndef SWL_REGS_SVH
`define SWL_REGS_SVH
`define SWL_CLK_MHZ 100
`define SWL_BIT_MAX_NS 10000
`define SWL_DEACT_NS 30000
`define SWL_SAVE_NS 10000000
`define SWL_RESUME_IDLE_BITS 4'h8
`define SWL_RESUME_SOF_BITS 3'h4
`define SWL_FIFO_WIDTH 8
`define SWL_FIFO_DEPTH 16
`define SWL_CNT_W 16
`define SWL_SAVE_W 20
`endif

// ### rtl/swl_fifo.sv
`timescale 1ns/10ps
module swl_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic in_valid_in,
  output logic in_ready_out,
  input wire logic [WIDTH-1:0] in_data_in,
  output logic out_valid_out,
  input wire logic out_ready_in,
  output logic [WIDTH-1:0] out_data_out
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wr;
    logic [AW-1:0] rd;
    logic [AW:0] cnt;
  } swl_fifo_state_t;

  swl_fifo_state_t q_reg;
  swl_fifo_state_t q_next;
  logic push;
  logic pop;

  assign in_ready_out = (q_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid_out = (q_reg.cnt != '0);
  assign out_data_out = q_reg.mem[q_reg.rd];
  assign push = in_valid_in & in_ready_out;
  assign pop = out_valid_out & out_ready_in;

  always_comb begin
    q_next = q_reg;
    if (push) begin
      q_next.mem[q_reg.wr] = in_data_in;
      q_next.wr = q_reg.wr + AW'(1);
    end
    if (pop) begin
      q_next.rd = q_reg.rd + AW'(1);
    end
    q_next.cnt = q_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end
endmodule : swl_fifo

// ### rtl/swl_phy.sv
`timescale 1ns/10ps
`include "swl_regs.svh"
module swl_phy #(
  parameter int SAVE_CYC = (`SWL_SAVE_NS / 1000) * `SWL_CLK_MHZ
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic shared_line_in,
  output logic slave_current_out,
  input wire logic [`SWL_FIFO_WIDTH-1:0] tx_data_in,
  input wire logic tx_valid_in,
  output logic tx_ready_out,
  output logic rx_bit_out,
  output logic rx_valid_out,
  output swl_pkg::swl_link_t link_state_out,
  input wire logic others_idle_in,
  input wire logic low_power_req_in,
  input wire logic full_power_cmd_in,
  output swl_pkg::swl_pwr_t pwr_status_out
);
  // Longest bit (10 us) rounds down; a high run beyond it can only be a suspend
  localparam int BIT_MAX_CYC = (`SWL_BIT_MAX_NS * `SWL_CLK_MHZ) / 1000;
  // Least deactivation time rounds up
  localparam int DEACT_CYC = (`SWL_DEACT_NS * `SWL_CLK_MHZ + 999) / 1000;
  localparam logic [`SWL_CNT_W-1:0] BIT_MAX = `SWL_CNT_W'(BIT_MAX_CYC);
  localparam logic [`SWL_CNT_W-1:0] DEACT = `SWL_CNT_W'(DEACT_CYC);
  localparam logic [`SWL_SAVE_W-1:0] SAVE_LAST = `SWL_SAVE_W'(SAVE_CYC - 1);

  swl_pkg::swl_phy_state_t q_reg;
  swl_pkg::swl_phy_state_t q_next;
  logic rise;
  logic fall;
  logic tx_slot;
  logic tx_pop;
  logic fifo_valid;
  logic [`SWL_FIFO_WIDTH-1:0] fifo_data;

  ////////////////////////////////////////////////////////////////////////////
  // Transmit buffer: user pushes bytes, the link drains one bit per master bit

  swl_fifo #(
    .WIDTH(`SWL_FIFO_WIDTH),
    .DEPTH(`SWL_FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_in(clk_in),
    .reset_n_in(reset_n_in),
    .in_valid_in(tx_valid_in),
    .in_ready_out(tx_ready_out),
    .in_data_in(tx_data_in),
    .out_valid_out(fifo_valid),
    .out_ready_in(tx_pop),
    .out_data_out(fifo_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Edges of the synchronised line

  assign rise = q_reg.sync2 & ~q_reg.line_d;
  assign fall = ~q_reg.sync2 & q_reg.line_d;
  // Slave bits go out only on a falling edge, so the current settles while low
  assign tx_slot = fall && (q_reg.link == swl_pkg::SWL_LINK_ACTIVE ||
                            q_reg.link == swl_pkg::SWL_LINK_RESUMING);
  assign tx_pop = tx_slot && (q_reg.sh_cnt == 4'h0) && fifo_valid;

  assign slave_current_out = q_reg.cur;
  assign rx_bit_out = q_reg.rx_bit;
  assign rx_valid_out = q_reg.rx_valid;
  assign link_state_out = q_reg.link;
  assign pwr_status_out = q_reg.pwr;

  function automatic logic [`SWL_CNT_W-1:0] sat_inc(input logic [`SWL_CNT_W-1:0] v);
    sat_inc = (v == '1) ? v : v + `SWL_CNT_W'(1);
  endfunction : sat_inc

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    q_next = q_reg;
    q_next.sync1 = shared_line_in;
    q_next.sync2 = q_reg.sync1;
    q_next.line_d = q_reg.sync2;
    q_next.rx_valid = 1'b0;

    // Period and high time measured per bit, from its own rising edge
    if (rise) begin
      q_next.per_cnt = `SWL_CNT_W'(1);
      q_next.high_cnt = `SWL_CNT_W'(1);
      q_next.have_edge = 1'b1;
    end else begin
      q_next.per_cnt = sat_inc(q_reg.per_cnt);
      if (q_reg.sync2) begin
        q_next.high_cnt = sat_inc(q_reg.high_cnt);
      end
    end
    q_next.low_cnt = q_reg.sync2 ? '0 : sat_inc(q_reg.low_cnt);

    // Threshold at half period leaves margin to both 30 and 70 percent marks
    if (rise && q_reg.have_edge && (q_reg.link == swl_pkg::SWL_LINK_ACTIVE ||
                                    q_reg.link == swl_pkg::SWL_LINK_RESUMING)) begin
      q_next.rx_valid = 1'b1;
      q_next.rx_bit = ({q_reg.high_cnt, 1'b0} > {1'b0, q_reg.per_cnt});
    end

    case (q_reg.link)
      swl_pkg::SWL_LINK_OFF: begin
        q_next.cur = 1'b0;
        q_next.sh_cnt = 4'h0;
        q_next.have_edge = 1'b0;
        if (rise) begin
          q_next.link = swl_pkg::SWL_LINK_PAUSED;
        end
      end
      swl_pkg::SWL_LINK_PAUSED: begin
        q_next.have_edge = 1'b0;
        if (fall) begin
          q_next.link = swl_pkg::SWL_LINK_RESUMING;
          q_next.idle_cnt = 4'h0;
        end else if (q_reg.sync2 && fifo_valid) begin
          q_next.cur = 1'b1;
          q_next.link = swl_pkg::SWL_LINK_WAKE;
        end
      end
      swl_pkg::SWL_LINK_RESUMING: begin
        if (q_reg.low_cnt >= DEACT) begin
          q_next.link = swl_pkg::SWL_LINK_OFF;
          q_next.cur = 1'b0;
        end else if (rise) begin
          // First rise closes the transition sequence, eight idle bits follow
          if (q_reg.idle_cnt == `SWL_RESUME_IDLE_BITS) begin
            q_next.link = swl_pkg::SWL_LINK_ACTIVE;
          end else begin
            q_next.idle_cnt = q_reg.idle_cnt + 4'h1;
          end
        end
      end
      swl_pkg::SWL_LINK_WAKE: begin
        if (q_reg.low_cnt >= DEACT) begin
          q_next.link = swl_pkg::SWL_LINK_OFF;
          q_next.cur = 1'b0;
        end else if (fall) begin
          q_next.cur = 1'b0;
        end else if (rise) begin
          q_next.link = swl_pkg::SWL_LINK_ACTIVE;
          q_next.resp_wait = 1'b1;
          q_next.resp_cnt = 3'h0;
        end
      end
      swl_pkg::SWL_LINK_ACTIVE: begin
        if (q_reg.sync2 && q_reg.high_cnt > BIT_MAX) begin
          q_next.link = swl_pkg::SWL_LINK_PAUSED;
          q_next.sh_cnt = 4'h0;
          q_next.resp_wait = 1'b0;
        end
      end
      default: begin
        q_next.link = swl_pkg::SWL_LINK_OFF;
      end
    endcase

    // Serialiser, MSB first; an empty buffer sends zero-valued idle bits
    if (tx_slot) begin
      if (q_reg.sh_cnt != 4'h0) begin
        q_next.cur = q_reg.sh[`SWL_FIFO_WIDTH-1];
        q_next.sh = {q_reg.sh[`SWL_FIFO_WIDTH-2:0], 1'b0};
        q_next.sh_cnt = q_reg.sh_cnt - 4'h1;
      end else if (fifo_valid) begin
        q_next.cur = fifo_data[`SWL_FIFO_WIDTH-1];
        q_next.sh = {fifo_data[`SWL_FIFO_WIDTH-2:0], 1'b0};
        q_next.sh_cnt = 4'(`SWL_FIFO_WIDTH - 1);
      end else begin
        q_next.cur = 1'b0;
      end
    end

    // Bits elapsed between a slave resume and the first transmitted byte
    if (q_reg.resp_wait) begin
      if (tx_pop) begin
        q_next.resp_wait = 1'b0;
      end else if (rise && q_reg.resp_cnt != 3'h7) begin
        q_next.resp_cnt = q_reg.resp_cnt + 3'h1;
      end
    end

    if (q_reg.link == swl_pkg::SWL_LINK_ACTIVE) begin
      q_next.pwr.operational = 1'b1;
    end
    // Low power only before any upper-layer return to full power
    if (full_power_cmd_in) begin
      q_next.pwr.low_power = 1'b0;
      q_next.full_locked = 1'b1;
    end else if (low_power_req_in && !q_reg.full_locked &&
                 q_reg.link != swl_pkg::SWL_LINK_OFF) begin
      q_next.pwr.low_power = 1'b1;
    end

    if (q_reg.link == swl_pkg::SWL_LINK_OFF && others_idle_in) begin
      if (q_reg.save_cnt == SAVE_LAST) begin
        q_next.pwr.power_save = 1'b1;
      end else begin
        q_next.save_cnt = q_reg.save_cnt + `SWL_SAVE_W'(1);
      end
    end else begin
      q_next.save_cnt = '0;
      q_next.pwr.power_save = 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      q_reg <= '{link: swl_pkg::SWL_LINK_OFF, default: '0};
    end else begin
      q_reg <= q_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);

  sequence s_wake_entry;
    q_reg.link == swl_pkg::SWL_LINK_PAUSED ##1 q_reg.link == swl_pkg::SWL_LINK_WAKE;
  endsequence

  sequence s_active_entry;
    q_reg.link == swl_pkg::SWL_LINK_RESUMING ##1 q_reg.link == swl_pkg::SWL_LINK_ACTIVE;
  endsequence

  property p_decode;
    rise && q_reg.have_edge && q_reg.link == swl_pkg::SWL_LINK_ACTIVE |=>
      rx_valid_out && (rx_bit_out == ($past(q_reg.high_cnt) > ($past(q_reg.per_cnt) >> 1)));
  endproperty
  a_decode: assert property (p_decode) else $error("bit decode wrong");

  property p_cur_low;
    $changed(slave_current_out) |->
      !$past(q_reg.sync2) || (q_reg.link == swl_pkg::SWL_LINK_WAKE && slave_current_out);
  endproperty
  a_cur_low: assert property (p_cur_low) else $error("current changed while high");

  property p_off_quiet;
    q_reg.link == swl_pkg::SWL_LINK_OFF ##1 q_reg.link == swl_pkg::SWL_LINK_OFF |->
      !slave_current_out;
  endproperty
  a_off_quiet: assert property (p_off_quiet) else $error("current while deactivated");

  property p_paused_exit;
    q_reg.link == swl_pkg::SWL_LINK_PAUSED ##1 q_reg.link != swl_pkg::SWL_LINK_PAUSED |->
      q_reg.link inside {swl_pkg::SWL_LINK_RESUMING, swl_pkg::SWL_LINK_WAKE};
  endproperty
  a_paused_exit: assert property (p_paused_exit) else $error("bad exit from pause");

  property p_active_exit;
    q_reg.link == swl_pkg::SWL_LINK_ACTIVE ##1 q_reg.link != swl_pkg::SWL_LINK_ACTIVE |->
      q_reg.link == swl_pkg::SWL_LINK_PAUSED && $past(q_reg.high_cnt) > BIT_MAX;
  endproperty
  a_active_exit: assert property (p_active_exit) else $error("active left without suspend");

  property p_resume_count;
    s_active_entry |-> $past(q_reg.idle_cnt) == `SWL_RESUME_IDLE_BITS && $past(rise);
  endproperty
  a_resume_count: assert property (p_resume_count) else $error("resume idle count wrong");

  property p_deact;
    q_reg.link inside {swl_pkg::SWL_LINK_RESUMING, swl_pkg::SWL_LINK_WAKE} &&
      q_reg.low_cnt == DEACT |=> q_reg.link == swl_pkg::SWL_LINK_OFF;
  endproperty
  a_deact: assert property (p_deact) else $error("long low not deactivating");

  property p_resume_tx;
    tx_slot && q_reg.link == swl_pkg::SWL_LINK_RESUMING && q_reg.sh_cnt == 4'h0 &&
      fifo_valid |=> q_reg.sh_cnt == 4'h7 &&
      slave_current_out == $past(fifo_data[`SWL_FIFO_WIDTH-1]);
  endproperty
  a_resume_tx: assert property (p_resume_tx) else $error("no send during resume");

  property p_wake;
    s_wake_entry |-> slave_current_out ##1 (slave_current_out || !$past(q_reg.sync2));
  endproperty
  a_wake: assert property (p_wake) else $error("wake current missing");

  property p_sof_limit;
    q_reg.resp_wait |-> q_reg.resp_cnt <= `SWL_RESUME_SOF_BITS;
  endproperty
  a_sof_limit: assert property (p_sof_limit) else $error("frame start too late");

  property p_operational;
    q_reg.link == swl_pkg::SWL_LINK_ACTIVE |=> pwr_status_out.operational [*3];
  endproperty
  a_operational: assert property (p_operational) else $error("not operational");

  property p_low_power;
    low_power_req_in && !full_power_cmd_in && !q_reg.full_locked &&
      q_reg.link != swl_pkg::SWL_LINK_OFF |=> pwr_status_out.low_power;
  endproperty
  a_low_power: assert property (p_low_power) else $error("low power not entered");

  property p_no_low;
    $rose(pwr_status_out.low_power) |-> !$past(q_reg.full_locked);
  endproperty
  a_no_low: assert property (p_no_low) else $error("full to low power");

  property p_save;
    q_reg.link == swl_pkg::SWL_LINK_OFF && others_idle_in && q_reg.save_cnt == SAVE_LAST |=>
      pwr_status_out.power_save;
  endproperty
  a_save: assert property (p_save) else $error("power saving late");

  property p_save_exit;
    pwr_status_out.power_save && q_reg.link != swl_pkg::SWL_LINK_OFF |=>
      !pwr_status_out.power_save;
  endproperty
  a_save_exit: assert property (p_save_exit) else $error("power saving held");
endmodule : swl_phy
